// ### core/rcwd_top.sv
// Runaway code watchdog: modulus-loaded 16-bit down-counter with reset request.
// How it works
// - A 16-bit counter counts down every enabled cycle on its own.
// - An underflow with no service raises the system reset request.
// - Software writes a 16-bit modulus that the counter starts from.
// - Only two successive service writes, first key then second key, count.
// - A completed service reloads the counter from the modulus.
`include "rcwd_params.svh"
module rcwd_top
    import rcwd_pkg::*;
(
    // Clock, reset and enable.
    clk,
    rst,
    ce,
    // Software side.
    mod_wr,
    mod_data,
    svc_wr,
    svc_data,
    // Status and reset request.
    count,
    modulus,
    reset_req
);
    input  wire logic        clk;
    input  wire logic        rst;
    input  wire logic        ce;
    input  wire logic        mod_wr;
    input  wire logic [15:0] mod_data;
    input  wire logic        svc_wr;
    input  wire logic [15:0] svc_data;
    output logic      [15:0] count;
    output logic      [15:0] modulus;
    output logic             reset_req;

    logic [15:0] cnt_reg;
    logic [15:0] mod_reg;
    logic        req_reg;
    logic        load_reg;
    logic        underflow;
    logic [15:0] since_reg;
    logic [15:0] mod_seen_reg;
    rcwd_svc_if  svc_bus ();

    // True for the count value after which the counter wraps.
    function automatic logic rcwd_at_zero(input logic [15:0] value);
        return value == `RCWD_ZERO;
    endfunction : rcwd_at_zero

    assign svc_bus.wr   = svc_wr;
    assign svc_bus.data = svc_data;

    // A service in the underflow cycle wins, so no request is raised then.
    assign underflow = ce && !load_reg && !svc_bus.done && rcwd_at_zero(cnt_reg);

    rcwd_service u_service (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .svc (svc_bus.tracker)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mod_reg <= `RCWD_MOD_RST;
        end else if (ce && mod_wr) begin
            mod_reg <= mod_data;
        end
    end

    // After reset the first enabled cycle loads the modulus.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_reg <= 1'b1;
        end else if (ce) begin
            load_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= `RCWD_MOD_RST;
        end else if (ce) begin
            if (load_reg || svc_bus.done) begin
                cnt_reg <= mod_reg;
            end else if (rcwd_at_zero(cnt_reg)) begin
                cnt_reg <= mod_reg;
            end else begin
                cnt_reg <= cnt_reg - `RCWD_ONE;
            end
        end
    end

    // Request is sticky until the system reset it causes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_reg <= 1'b0;
        end else if (underflow) begin
            req_reg <= 1'b1;
        end
    end

    assign count     = cnt_reg;
    assign modulus   = mod_reg;
    assign reset_req = req_reg;


    // Checker helper: enabled cycles since the last reload and the modulus taken then.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_reg    <= `RCWD_ZERO;
            mod_seen_reg <= `RCWD_MOD_RST;
        end else if (ce) begin
            if (load_reg || svc_bus.done || underflow) begin
                since_reg    <= `RCWD_ZERO;
                mod_seen_reg <= mod_reg;
            end else begin
                since_reg <= since_reg + `RCWD_ONE;
            end
        end
    end

    sequence s_underflow;
        ce && !load_reg && !svc_bus.done && cnt_reg == `RCWD_ZERO;
    endsequence

    sequence s_stepping;
        ce && !load_reg && !svc_bus.done && cnt_reg != `RCWD_ZERO;
    endsequence

    sequence s_serviced;
        svc_bus.done;
    endsequence

    sequence s_after_reset;
        load_reg && ce;
    endsequence

    property p_underflow;
        @(posedge clk) disable iff (rst)
        s_underflow |=> reset_req;
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("Underflow did not request reset.");

    property p_underflow_reload;
        @(posedge clk) disable iff (rst)
        s_underflow |=> cnt_reg == $past(mod_reg);
    endproperty
    a_underflow_reload: assert property (p_underflow_reload)
        else $error("Counter did not wrap to the modulus.");

    property p_timeout;
        @(posedge clk) disable iff (rst)
        s_underflow |-> since_reg == mod_seen_reg;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("Timeout length differs from the modulus.");

    property p_countdown;
        @(posedge clk) disable iff (rst)
        s_stepping |=> cnt_reg == $past(cnt_reg) - `RCWD_ONE;
    endproperty
    a_countdown: assert property (p_countdown)
        else $error("Counter did not step down.");

    property p_reload;
        @(posedge clk) disable iff (rst)
        s_serviced |=> cnt_reg == $past(mod_reg);
    endproperty
    a_reload: assert property (p_reload)
        else $error("Service did not reload counter.");

    property p_modwrite;
        @(posedge clk) disable iff (rst)
        ce && mod_wr |=> mod_reg == $past(mod_data);
    endproperty
    a_modwrite: assert property (p_modwrite)
        else $error("Modulus write lost.");

    property p_modhold;
        @(posedge clk) disable iff (rst)
        !(ce && mod_wr) |=> $stable(mod_reg);
    endproperty
    a_modhold: assert property (p_modhold)
        else $error("Modulus changed without a write.");

    property p_resetload;
        @(posedge clk) disable iff (rst)
        s_after_reset |=> cnt_reg == $past(mod_reg) && !reset_req;
    endproperty
    a_resetload: assert property (p_resetload)
        else $error("Counter not loaded after reset.");

    property p_req_sticky;
        @(posedge clk) disable iff (rst)
        reset_req |=> reset_req;
    endproperty
    a_req_sticky: assert property (p_req_sticky)
        else $error("Reset request dropped before reset.");

    property p_no_false_req;
        @(posedge clk) disable iff (rst)
        !reset_req && !(ce && !load_reg && !svc_bus.done && cnt_reg == `RCWD_ZERO)
        |=> !reset_req;
    endproperty
    a_no_false_req: assert property (p_no_false_req)
        else $error("Reset requested without an underflow.");

    property p_freeze;
        @(posedge clk) disable iff (rst)
        !ce |=> $stable(cnt_reg) && $stable(mod_reg) && $stable(reset_req);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("State moved while the enable was low.");
endmodule : rcwd_top

// ### shared/rcwd_params.svh
// Constants for the runaway code watchdog.
`ifndef RCWD_PARAMS_SVH
`define RCWD_PARAMS_SVH
`define RCWD_CNT_W      16
`define RCWD_MOD_RST    16'hFFFF
`define RCWD_KEY_FIRST  16'h5555
`define RCWD_KEY_SECOND 16'hAAAA
`define RCWD_ZERO       16'h0000
`define RCWD_ONE        16'h0001
`endif

// ### shared/rcwd_pkg.sv
// Types for the runaway code watchdog.
package rcwd_pkg;
    typedef enum logic [1:0] {
        RCWD_SVC_IDLE,
        RCWD_SVC_ARMED
    } rcwd_svc_t;
endpackage : rcwd_pkg

// ### shared/rcwd_svc_if.sv
// Service sequence signals between the watchdog top and its service tracker.
interface rcwd_svc_if;
    logic        wr;
    logic [15:0] data;
    logic        done;
    modport tracker (input wr, input data, output done);
    modport owner   (output wr, output data, input done);
endinterface : rcwd_svc_if

// ### core/rcwd_service.sv
// Two-write service sequence tracker.
`include "rcwd_params.svh"
module rcwd_service
    import rcwd_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    // Service port.
    rcwd_svc_if.tracker svc
);
    rcwd_svc_t state_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= RCWD_SVC_IDLE;
        end else if (ce && svc.wr) begin
            unique case (state_reg)
                RCWD_SVC_IDLE: begin
                    if (svc.data == `RCWD_KEY_FIRST) begin
                        state_reg <= RCWD_SVC_ARMED;
                    end
                end
                RCWD_SVC_ARMED: begin
                    // A second write other than the first key closes the sequence; a repeated first key keeps it armed.
                    state_reg <= (svc.data == `RCWD_KEY_FIRST) ? RCWD_SVC_ARMED
                                                                 : RCWD_SVC_IDLE;
                end
                default: begin
                    state_reg <= RCWD_SVC_IDLE;
                end
            endcase
        end
    end

    // Done only on the second of two successive correct writes.
    assign svc.done = ce && svc.wr && (state_reg == RCWD_SVC_ARMED)
                      && (svc.data == `RCWD_KEY_SECOND);

    sequence s_first_key;
        ce && svc.wr && svc.data == `RCWD_KEY_FIRST;
    endsequence

    property p_arm;
        @(posedge clk) disable iff (rst)
        s_first_key |=> state_reg == RCWD_SVC_ARMED;
    endproperty
    a_arm: assert property (p_arm)
        else $error("First key did not arm the service sequence.");

    property p_single_write;
        @(posedge clk) disable iff (rst)
        ce && svc.wr && state_reg == RCWD_SVC_IDLE |-> !svc.done;
    endproperty
    a_single_write: assert property (p_single_write)
        else $error("Service completed on a single write.");

    property p_drop;
        @(posedge clk) disable iff (rst)
        ce && svc.wr && state_reg == RCWD_SVC_ARMED && svc.data != `RCWD_KEY_FIRST
        |=> state_reg == RCWD_SVC_IDLE;
    endproperty
    a_drop: assert property (p_drop)
        else $error("Service sequence not closed after second write.");
endmodule : rcwd_service

// ### bench/rcwd_top_tb_top.sv
// Self-checking bench for the runaway code watchdog.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module rcwd_top_tb_top
    import rcwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] m; logic [15:0] k1; logic [15:0] k2; logic ok;} rcwd_row_t;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        ce       = 1'b1;
    logic        mod_wr   = 1'b0;
    logic [15:0] mod_data = 16'h0000;
    logic        svc_wr   = 1'b0;
    logic [15:0] svc_data = 16'h0000;
    logic [15:0] count;
    logic [15:0] modulus;
    logic        reset_req;
    int          n_errors = 0;
    int          checks   = 0;
    rcwd_row_t   rows [4] = '{'{16'h0010, 16'h5555, 16'hAAAA, 1'b1},
                              '{16'h0010, 16'hAAAA, 16'h5555, 1'b0},
                              '{16'h0010, 16'h5555, 16'h5555, 1'b0},
                              '{16'h0010, 16'h1234, 16'hAAAA, 1'b0}};
    rcwd_top u_rcwd_top (.clk(clk), .rst(rst), .ce(ce), .mod_wr(mod_wr),
        .mod_data(mod_data), .svc_wr(svc_wr), .svc_data(svc_data),
        .count(count), .modulus(modulus), .reset_req(reset_req));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK(count, 16'hFFFF)
        `CHK(modulus, 16'hFFFF)
        `CHK(reset_req, 1'b0)
        rst <= 1'b0;
    endtask : do_reset
    task automatic wr_mod(input logic [15:0] v);
        @(posedge clk);
        mod_wr <= 1'b1;
        mod_data <= v;
        @(posedge clk);
        mod_wr <= 1'b0;
    endtask : wr_mod
    task automatic svc(input logic [15:0] k);
        @(posedge clk);
        svc_wr <= 1'b1;
        svc_data <= k;
        @(posedge clk);
        svc_wr <= 1'b0;
    endtask : svc
    task automatic end_of_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        foreach (rows[i]) begin
            do_reset();
            wr_mod(rows[i].m);
            svc(rows[i].k1);
            svc(rows[i].k2);
            #1;
            `CHK(count === rows[i].m, rows[i].ok)
            `CHK(modulus, rows[i].m)
        end
        // Servicing every four cycles against a timeout of five keeps the request low.
        do_reset();
        wr_mod(16'h0004);
        repeat (3) begin
            svc(16'h5555);
            svc(16'hAAAA);
        end
        #1;
        `CHK(count, 16'h0004)
        `CHK(reset_req, 1'b0)
        repeat (4) @(posedge clk);
        #1;
        `CHK(count, 16'h0000)
        `CHK(reset_req, 1'b0)
        @(posedge clk);
        #1;
        `CHK(reset_req, 1'b1)
        `CHK(count, 16'h0004)
        // A half-done service must not survive a reset.
        svc(16'h5555);
        do_reset();
        svc(16'hAAAA);
        #1;
        `CHK(count === 16'hFFFF, 1'b0)
        `CHK(reset_req, 1'b0)
        // With the enable low the count freezes and a first key is ignored.
        @(posedge clk);
        ce <= 1'b0;
        svc_wr <= 1'b1;
        svc_data <= 16'h5555;
        repeat (3) @(posedge clk);
        #1;
        `CHK(count, 16'hFFFD)
        @(posedge clk);
        ce <= 1'b1;
        svc_data <= 16'hAAAA;
        @(posedge clk);
        svc_wr <= 1'b0;
        #1;
        `CHK(count, 16'hFFFC)
        end_of_test();
    end
endmodule : rcwd_top_tb_top
